// ==== core/nrs_host.sv ====
// nand read-select host controller: issues read-side command sequences and collects output bytes
`timescale 1ns/10ps
module nrs_host #(
  parameter int DATA_W = 8,
  parameter int COL_W = 16,
  parameter int ROW_W = 24,
  parameter int LEN_W = 12
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_op,
  input wire logic [COL_W-1:0] req_col,
  input wire logic [ROW_W-1:0] req_row,
  input wire logic [LEN_W-1:0] req_len,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DATA_W-1:0] rd_data,
  output logic busy,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic chip_enable_n,
  input wire logic ready_busy_n,
  input wire logic [DATA_W-1:0] io_in,
  output logic [DATA_W-1:0] io_out,
  output logic io_oe
);
  nrs_pkg::nrs_state_e st_q;
  nrs_pkg::nrs_state_e st_d;
  logic [2:0] op_q;
  logic [COL_W-1:0] col_q;
  logic [ROW_W-1:0] row_q;
  logic [LEN_W-1:0] left_q;
  logic [2:0] acnt_q;
  logic [7:0] tcnt_q;
  logic ph_q;
  logic [DATA_W-1:0] buf_q [2];
  logic [1:0] cnt_q;
  logic wp_q;
  logic rp_q;

  wire tick = (tcnt_q == 8'h00);
  wire phase_end = tick && ph_q;
  wire buf_full = (cnt_q == 2'd2);
  wire push = (st_q == nrs_pkg::ST_READ) && phase_end;
  wire pop = rd_valid && rd_ready;
  // address cycle count per op
  wire [2:0] n_addr = (op_q == nrs_pkg::OP_PLANE_SEL) ? 3'(nrs_pkg::COL_CYCLES + nrs_pkg::ROW_CYCLES) : // [R8]
                      (op_q == nrs_pkg::OP_COL_CHANGE) ? 3'(nrs_pkg::COL_CYCLES) : // [R5] [R11]
                      (op_q == nrs_pkg::OP_ID_DEVICE || op_q == nrs_pkg::OP_ID_SIG || op_q == nrs_pkg::OP_PARAM) ? 3'd1 :
                      3'd0;
  wire has_conf = (op_q == nrs_pkg::OP_PLANE_SEL) || (op_q == nrs_pkg::OP_COL_CHANGE);
  // no op selects the enhanced status code, so a dual-plane read is never disturbed [R4]
  wire [7:0] cmd_byte = (op_q == nrs_pkg::OP_PLANE_SEL) ? nrs_pkg::CMD_PLANE_SEL : // [R2] [R3]
                        (op_q == nrs_pkg::OP_COL_CHANGE) ? nrs_pkg::CMD_COL_CHANGE : // [R18]
                        (op_q == nrs_pkg::OP_PARAM) ? nrs_pkg::CMD_PARAM_PAGE : // [R17]
                        (op_q == nrs_pkg::OP_STATUS_REREAD) ? nrs_pkg::CMD_READ_MODE : // [R21]
                        nrs_pkg::CMD_IDENTIFY; // [R12] [R13]
  wire [ROW_W+COL_W-1:0] addr_vec = {row_q, col_q};
  wire [7:0] addr_byte = (op_q == nrs_pkg::OP_ID_DEVICE) ? nrs_pkg::ID_ADDR_DEVICE : // [R12]
                         (op_q == nrs_pkg::OP_ID_SIG) ? nrs_pkg::ID_ADDR_SIG : // [R13]
                         (op_q == nrs_pkg::OP_PARAM) ? 8'h00 :
                         addr_vec[acnt_q*8 +: 8];
  wire wr_phase = (st_q == nrs_pkg::ST_CMD) || (st_q == nrs_pkg::ST_ADDR) || (st_q == nrs_pkg::ST_CONF);

  assign req_ready = (st_q == nrs_pkg::ST_IDLE);
  assign busy = !req_ready;
  assign rd_valid = (cnt_q != 2'd0);
  assign rd_data = buf_q[rp_q];
  assign cmd_latch = (st_q == nrs_pkg::ST_CMD) || (st_q == nrs_pkg::ST_CONF);
  assign addr_latch = (st_q == nrs_pkg::ST_ADDR);
  assign write_strobe_n = !(wr_phase && !ph_q);
  // strobe low only while buffer has room, so a stalled receiver loses no byte
  assign read_strobe_n = !((st_q == nrs_pkg::ST_READ) && !ph_q && !buf_full); // [R22]
  assign chip_enable_n = (st_q == nrs_pkg::ST_IDLE);
  assign io_oe = wr_phase;
  assign io_out = (st_q == nrs_pkg::ST_ADDR) ? DATA_W'(addr_byte) :
                  (st_q == nrs_pkg::ST_CONF) ? DATA_W'(nrs_pkg::CMD_CONFIRM) : DATA_W'(cmd_byte);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      nrs_pkg::ST_IDLE:
        if (req_valid)
          st_d = nrs_pkg::ST_WAIT_RDY;
      nrs_pkg::ST_WAIT_RDY:
        if (ready_busy_n)
          st_d = nrs_pkg::ST_CMD; // [R7] [R20] [R1]
      nrs_pkg::ST_CMD:
        if (phase_end)
          st_d = (n_addr != 3'd0) ? nrs_pkg::ST_ADDR : nrs_pkg::ST_GAP;
      nrs_pkg::ST_ADDR:
        if (phase_end && acnt_q == n_addr - 3'd1)
          st_d = has_conf ? nrs_pkg::ST_CONF : nrs_pkg::ST_GAP;
      nrs_pkg::ST_CONF:
        if (phase_end)
          st_d = nrs_pkg::ST_GAP;
      nrs_pkg::ST_GAP:
        if (tick)
          st_d = (left_q == '0) ? nrs_pkg::ST_IDLE : nrs_pkg::ST_READ; // [R9]
      nrs_pkg::ST_READ:
        if (push && left_q == LEN_W'(1))
          st_d = nrs_pkg::ST_IDLE; // [R10] [R14]
      default:
        st_d = nrs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= nrs_pkg::ST_IDLE;
      op_q <= 3'h0;
      col_q <= '0;
      row_q <= '0;
      left_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      if (req_valid && req_ready)
      begin
        op_q <= req_op;
        col_q <= req_col; // [R6] caller keeps column inside the loaded page
        row_q <= req_row;
        left_q <= req_len;
      end
      else if (push)
        left_q <= left_q - LEN_W'(1);
    end
  end

  // strobe phase timer: low half then high half, each STROBE_CYC; gap uses WHR_CYC
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tcnt_q <= 8'h00;
      ph_q <= 1'b0;
      acnt_q <= 3'h0;
    end
    else if (st_q != st_d)
    begin
      ph_q <= 1'b0;
      tcnt_q <= (st_d == nrs_pkg::ST_GAP) ? 8'(nrs_pkg::WHR_CYC - 1) : 8'(nrs_pkg::STROBE_CYC - 1);
      acnt_q <= 3'h0;
    end
    else if (st_q == nrs_pkg::ST_READ && !ph_q && buf_full)
      tcnt_q <= 8'(nrs_pkg::STROBE_CYC - 1);
    else if (tick)
    begin
      ph_q <= !ph_q;
      tcnt_q <= 8'(nrs_pkg::STROBE_CYC - 1);
      if (phase_end && st_q == nrs_pkg::ST_ADDR)
        acnt_q <= acnt_q + 3'd1;
    end
    else
      tcnt_q <= tcnt_q - 8'h01;
  end

  // two-entry output buffer; data sampled at the end of the read strobe high half
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= 2'd0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        buf_q[wp_q] <= io_in; // [R15] [R16] [R19] upper lines passed as read
        wp_q <= !wp_q;
      end
      if (pop)
        rp_q <= !rp_q;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
endmodule

// ==== shared/nrs_pkg.sv ====
// package: command codes, pin timing counts and state encodings for the nand read-select host
//
// Functional notes
// R1 - device sets status bit 6 when both plane loads finish; host polls it (host waits for ready_busy_n high instead)
// R2 - host issues plane-select pair before reading first plane of dual-plane read
// R3 - host reissues plane-select pair to switch plane; output starts at new column
// R4 - host never issues enhanced status during a dual-plane read
// R5 - after page read, column-change: command, two column cycles, confirm
// R6 - column-change may repeat, target column stays inside loaded page
// R7 - plane-select accepted only while ready; host waits for ready first
// R8 - plane-select: command, two column, three row cycles, confirm byte
// R9 - host waits write-high-to-read delay after confirm before read strobe
// R10 - device stays in output mode until next valid command
// R11 - column move without plane change uses the column-change pair
// R12 - identify plus address zero returns five id bytes
// R13 - identify plus alternate address returns four signature bytes starting 4Fh
// R14 - device stays in identify output until next command
// R15 - sixteen-bit parts give id in low data lines only
// R16 - id bytes: maker, device, three product bytes
// R17 - parameter page command returns at least three redundant copies
// R18 - column-change accepted during parameter page output
// R19 - parameter bytes 80-83 give page size, second byte 08h
// R20 - dual-plane confirm loads both planes, ready_busy_n low meanwhile
// R21 - after status read, page read command restarts output at initial column
// R22 - device advances column pointer on each read strobe
package nrs_pkg;
  localparam logic [7:0] CMD_READ_MODE = 8'h00;
  localparam logic [7:0] CMD_READ_CONF = 8'h30;
  localparam logic [7:0] CMD_COL_CHANGE = 8'h05;
  localparam logic [7:0] CMD_PLANE_SEL = 8'h06;
  localparam logic [7:0] CMD_CONFIRM = 8'hE0;
  localparam logic [7:0] CMD_IDENTIFY = 8'h90;
  localparam logic [7:0] CMD_PARAM_PAGE = 8'hEC;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] ID_ADDR_DEVICE = 8'h00;
  localparam logic [7:0] ID_ADDR_SIG = 8'h20;
  localparam int STATUS_READY_BIT = 6;
  localparam int ID_DEVICE_LEN = 5;
  localparam int ID_SIG_LEN = 4;
  localparam int PARAM_COPIES = 3;
  localparam int PARAM_COPY_LEN = 256;
  localparam int COL_CYCLES = 2;
  localparam int ROW_CYCLES = 3;
  localparam int CLK_MHZ = 20;
  localparam int STROBE_NS = 50;
  localparam int WHR_NS = 80;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 : (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int WHR_CYC = (WHR_NS * CLK_MHZ + 999) / 1000;
  // op codes on the user side
  localparam logic [2:0] OP_COL_CHANGE = 3'h0;
  localparam logic [2:0] OP_PLANE_SEL = 3'h1;
  localparam logic [2:0] OP_ID_DEVICE = 3'h2;
  localparam logic [2:0] OP_ID_SIG = 3'h3;
  localparam logic [2:0] OP_PARAM = 3'h4;
  localparam logic [2:0] OP_STATUS_REREAD = 3'h5;
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_WAIT_RDY = 7'b000_0010,
    ST_CMD = 7'b000_0100,
    ST_ADDR = 7'b000_1000,
    ST_CONF = 7'b001_0000,
    ST_GAP = 7'b010_0000,
    ST_READ = 7'b100_0000
  } nrs_state_e;
endpackage

// ==== dv/nrs_monitor.sv ====
// checker: pin sequencing of the read-select host
`timescale 1ns/10ps
module nrs_monitor #(
  parameter int DATA_W = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic chip_enable_n,
  input wire logic ready_busy_n,
  input wire logic [DATA_W-1:0] io_out,
  input wire logic io_oe
);
  logic we_q;
  logic [7:0] lc_q;
  logic [2:0] ac_q;
  wire we_up = write_strobe_n & ~we_q;
  wire cmd_up = we_up & cmd_latch;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) we_q <= 1'b1;
    else we_q <= write_strobe_n;
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) lc_q <= 8'h00;
    else if (cmd_up) lc_q <= io_out[7:0];
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) ac_q <= 3'h0;
    else if (cmd_up) ac_q <= 3'h0;
    else if (we_up && addr_latch) ac_q <= ac_q + 3'h1;
  sequence s_conf(logic [7:0] c);
    cmd_up && io_out[7:0] == 8'hE0 && lc_q == c;
  endsequence
  sequence s_gap;
    read_strobe_n [*2];
  endsequence
  property p_whr; s_conf(8'h06) |=> s_gap; endproperty
  a_whr: assert property (p_whr) else $error("read strobe too soon after confirm");
  property p_plane_addr; s_conf(8'h06) |-> ac_q == 3'h5; endproperty
  a_plane_addr: assert property (p_plane_addr) else $error("plane select address count");
  property p_col_addr; s_conf(8'h05) |-> ac_q == 3'h2; endproperty
  a_col_addr: assert property (p_col_addr) else $error("column change address count");
  property p_no_enh; cmd_latch && !write_strobe_n |-> io_out[7:0] != 8'h78; endproperty
  a_no_enh: assert property (p_no_enh) else $error("enhanced status issued");
  property p_wait_rdy; !ready_busy_n |-> write_strobe_n && read_strobe_n; endproperty
  a_wait_rdy: assert property (p_wait_rdy) else $error("strobe while device busy");
  property p_id_addr; $fell(read_strobe_n) && lc_q inside {8'h90, 8'hEC} |-> ac_q == 3'h1; endproperty
  a_id_addr: assert property (p_id_addr) else $error("identify address count");
  property p_re_ce; !read_strobe_n |-> !chip_enable_n && !io_oe; endproperty
  a_re_ce: assert property (p_re_ce) else $error("read strobe without select");
  property p_hold; rd_valid && !rd_ready |=> rd_valid && $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("stalled output changed");
endmodule
bind nrs_host nrs_monitor #(.DATA_W(DATA_W)) u_nrs_monitor (.*);

// ==== dv/nrs_dev_model.sv ====
// device model: command decode and read-side output
`timescale 1ns/10ps
module nrs_dev_model #(
  parameter logic [7:0] ID [9] = '{default: 8'h00}
) (
  input wire logic hold_busy,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] io_out,
  output logic [7:0] io_in,
  output logic ready_busy_n
);
  logic [7:0] mode = 8'h00;
  logic [7:0] d;
  logic [7:0] a [5] = '{default: 8'h00};
  int n = 0;
  int ptr = 0;
  assign ready_busy_n = !hold_busy;
  always @(posedge write_strobe_n)
  begin
    if (cmd_latch)
      ptr = (io_out == 8'hE0) ? {a[1], a[0]} : 0;
    if (cmd_latch && io_out != 8'hE0 && io_out != 8'h05)
      mode = io_out;
    if (cmd_latch)
      n = 0;
    if (addr_latch)
      a[n % 5] = io_out;
    if (addr_latch)
      n++;
  end
  always_comb
    case (mode)
      8'h90: d = a[0][5] ? ID[5 + ptr % 4] : ID[ptr % 5];
      8'hEC: d = (ptr % 256 == 81) ? 8'h08 : (ptr % 256 inside {[80:83]}) ? 8'h00 : ptr[7:0];
      default: d = ptr[7:0] ^ {a[2][0], 7'h00};
    endcase
  initial io_in = 8'h5A;
  always @(negedge read_strobe_n)
    io_in = d;
  always @(posedge read_strobe_n)
  begin
    ptr++;
    #60;
    if (read_strobe_n)
      io_in = ~io_in;
  end
endmodule

// ==== dv/tb.sv ====
// testbench: read-select host against the device model
`timescale 1ns/10ps
module tb;
  // first two identity bytes are arbitrary
  localparam logic [7:0] IDX [9] = '{8'h3C, 8'h5A, 8'h90, 8'h15, 8'h04, 8'h4F, 8'h4E, 8'h46, 8'h49};
  logic mclk = 0, reset_n = 0, req_valid = 0, rd_ready = 0, hold_busy = 0;
  logic [2:0] req_op = 3'h0;
  logic [15:0] req_col = 16'h0000;
  logic [23:0] req_row = 24'h00_0000;
  logic [11:0] req_len = 12'h000;
  logic req_ready, rd_valid, busy, cmd_latch, addr_latch, write_strobe_n, read_strobe_n, chip_enable_n;
  logic ready_busy_n, io_oe;
  logic [7:0] rd_data, io_in, io_out;
  logic [7:0] q [$];
  int err_count = 0, num_checks = 0;
  nrs_host u_nrs_host (.*);
  nrs_dev_model #(.ID(IDX)) u_nrs_dev_model (.*);
  initial forever #25 mclk = ~mclk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("errors=%0d checks=%0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic run(input logic [2:0] op, input logic [15:0] col, input logic [23:0] row, input int len, stall);
    q = {};
    @(posedge mclk);
    #1 req_valid = 1;
    req_op = op;
    req_col = col;
    req_row = row;
    req_len = len[11:0];
    do @(negedge mclk); while (req_ready !== 1'b1);
    @(posedge mclk);
    #1 req_valid = 0;
    chk({7'h00, busy}, 8'h01);
    for (int k = 0; k < 3000 && q.size() < len; k++)
    begin
      if (k == stall) rd_ready = 1;
      @(negedge mclk);
      if (rd_valid === 1'b1 && rd_ready) q.push_back(rd_data);
      @(posedge mclk);
      #1;
    end
    rd_ready = 0;
    if (q.size() < len)
      err_count++;
  endtask
  task automatic t_col;
    run(3'h0, 16'h0012, 24'h00_0000, 3, 40);
    for (int i = 0; i < 3; i++) chk(q[i], 8'h12 + i[7:0]);
  endtask
  task automatic t_plane;
    hold_busy = 1;
    fork
      run(3'h1, 16'h0005, 24'h00_0001, 2, 0);
      begin
        repeat (30) @(negedge mclk);
        chk({7'h00, write_strobe_n}, 8'h01);
        @(posedge mclk);
        #1 hold_busy = 0;
      end
    join
    chk(q[0], 8'h85);
    chk(q[1], 8'h86);
    run(3'h1, 16'h0010, 24'h00_0000, 1, 0);
    chk(q[0], 8'h10);
  endtask
  task automatic t_id;
    run(3'h2, 16'h0000, 24'h00_0000, 5, 0);
    for (int i = 0; i < 5; i++) chk(q[i], IDX[i]);
    run(3'h3, 16'h0000, 24'h00_0000, 4, 0);
    for (int i = 0; i < 4; i++) chk(q[i], IDX[5 + i]);
  endtask
  task automatic t_param;
    run(3'h4, 16'h0000, 24'h00_0000, 84, 0);
    for (int i = 0; i < 4; i++) chk(q[80 + i], (i == 1) ? 8'h08 : 8'h00);
    run(3'h0, 16'h0151, 24'h00_0000, 1, 0);
    chk(q[0], 8'h08);
    run(3'h5, 16'h0000, 24'h00_0000, 2, 0);
    chk(q[1], 8'h01);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    #1 reset_n = 1;
    t_col;
    t_plane;
    t_id;
    t_param;
    close_out;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    close_out;
  end
endmodule
